// [rtl/ssx_pkg.sv]
// Constants and types shared by the subtract/special-page/halt execution unit
//--------------------------------------------------------------------------
// Summary of operation
// - Register subtract-with-borrow: file reg + ~acc + C; sets Z, DC, C.
// - Destination bit 0 writes accumulator; 1 writes back the file register.
// - File operand addresses registers 0 to 63 straight from the word.
// - Carry is inverted borrow: 0x05-0x06 with C=0 gives 0xFE, C=0.
// - Zero flag set on 0x00 result; 0x06-0x05 with C=0 gives 0x00, C=1.
// - Special-page store copies acc to register 0..15; acc kept.
// - Special-page load copies register 0..15 to acc; flags kept.
// - Halt clears watchdog counter and its prescaler to zero.
// - Register subtract: file reg - acc, no carry-in; sets Z, DC, C.
// - Immediate subtract-with-borrow always writes the accumulator.
// - Immediate operand is 8 bits; acc and borrow are subtracted from it.
//--------------------------------------------------------------------------
package ssx_pkg;

   //-----------------------------------------------------------------------
   // Register map (byte addresses)
   //-----------------------------------------------------------------------
   localparam logic [11:0] ADDR_INSTR   = 12'h000;
   localparam logic [11:0] ADDR_ACC     = 12'h004;
   localparam logic [11:0] ADDR_STATUS  = 12'h008;
   localparam logic [11:0] ADDR_WDT     = 12'h00C;
   localparam logic [11:0] ADDR_FREG    = 12'h100;
   localparam logic [11:0] ADDR_SPAGE   = 12'h200;

   //-----------------------------------------------------------------------
   // Instruction word fields
   //-----------------------------------------------------------------------
   localparam int OP_LSB    = 0;
   localparam int DEST_BIT  = 4;
   localparam int FIDX_LSB  = 8;
   localparam int SIDX_LSB  = 16;
   localparam int IMM_LSB   = 24;

   localparam logic [3:0] OP_NOP       = 4'h0;
   localparam logic [3:0] OP_REG_SBC   = 4'h1;
   localparam logic [3:0] OP_IMM_SBC   = 4'h2;
   localparam logic [3:0] OP_REG_SUB   = 4'h3;
   localparam logic [3:0] OP_SP_STORE  = 4'h4;
   localparam logic [3:0] OP_SP_LOAD   = 4'h5;
   localparam logic [3:0] OP_HALT      = 4'h6;

   //-----------------------------------------------------------------------
   // Status register bits
   //-----------------------------------------------------------------------
   localparam int ST_C     = 0;
   localparam int ST_DC    = 1;
   localparam int ST_Z     = 2;
   localparam int ST_PD_N  = 3;
   localparam int ST_TO_N  = 4;
   localparam int ST_HALT  = 5;

   //-----------------------------------------------------------------------
   // Reset values
   //-----------------------------------------------------------------------
   localparam logic [7:0] RST_ACC   = 8'h00;
   localparam logic [7:0] RST_WDT   = 8'h00;
   localparam logic [7:0] RST_PRE   = 8'h00;
   localparam logic       RST_TO_N  = 1'b1;
   localparam logic       RST_PD_N  = 1'b1;

   typedef enum logic [1:0] {
      SSX_RUN,
      SSX_HALT_PEND,
      SSX_HALTED
   } ssx_mode_t;

   typedef struct packed {
      logic [7:0] res;
      logic       dc;
      logic       c;
   } ssx_alu_t;

   typedef struct packed {
      ssx_mode_t        mode;
      logic [7:0]       acc;
      logic             c;
      logic             dc;
      logic             z;
      logic             to_n;
      logic             pd_n;
      logic [7:0]       wdt;
      logic [7:0]       pre;
      logic [31:0]      prdata;
      logic [63:0][7:0] freg;
      logic [15:0][7:0] spage;
   } ssx_state_t;

endpackage

// [rtl/ssx_exec.sv]
// Execution unit for subtract, special-page move and halt instructions
//
// Decided for this implementation: the APB register port and the register addresses.
module ssx_exec (
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   input  wire logic        PSEL,
   input  wire logic        PENABLE,
   input  wire logic        PWRITE,
   input  wire logic [11:0] PADDR,
   input  wire logic [31:0] PWDATA,
   output logic      [31:0] PRDATA,
   output logic             PREADY,
   output logic             PSLVERR,
   output logic             HALT_MODE
);

   //-----------------------------------------------------------------------
   // Functions
   //-----------------------------------------------------------------------
   // a + ~b + cin: carry and digit carry are inverted borrows
   function automatic ssx_pkg::ssx_alu_t sub8(input logic [7:0] a,
                                              input logic [7:0] b,
                                              input logic       cin);
      logic [8:0] full;
      logic [4:0] low;
      ssx_pkg::ssx_alu_t r;
      full  = {1'b0, a} + {1'b0, ~b} + {8'h00, cin};
      low   = {1'b0, a[3:0]} + {1'b0, ~b[3:0]} + {4'h0, cin};
      r.res = full[7:0];
      r.c   = full[8];
      r.dc  = low[4];
      return r;
   endfunction

   function automatic logic is_word(input logic [11:0] addr,
                                    input logic [11:0] base,
                                    input logic [11:0] span);
      return (addr >= base) && (addr < base + span) && (addr[1:0] == 2'b00);
   endfunction

   //-----------------------------------------------------------------------
   // Decode
   //-----------------------------------------------------------------------
   ssx_pkg::ssx_state_t s_r;
   ssx_pkg::ssx_state_t s_nxt;

   logic       setup;
   logic       access;
   logic       wr;
   logic       hit_freg;
   logic       hit_spage;
   logic       mapped;
   logic       exec;
   logic       refused;
   logic [3:0] ex_op;
   logic       ex_dest;
   logic [5:0] ex_fidx;
   logic [3:0] ex_sidx;
   logic [7:0] ex_imm;
   logic [5:0] a_fidx;
   logic [3:0] a_sidx;
   logic [31:0] rd_val;
   ssx_pkg::ssx_alu_t alu;

   assign setup     = PSEL && !PENABLE;
   assign access    = PSEL && PENABLE;
   assign wr        = access && PWRITE;
   assign hit_freg  = is_word(PADDR, ssx_pkg::ADDR_FREG, 12'h100);
   assign hit_spage = is_word(PADDR, ssx_pkg::ADDR_SPAGE, 12'h040);
   assign mapped    = hit_freg || hit_spage
                      || PADDR == ssx_pkg::ADDR_INSTR
                      || PADDR == ssx_pkg::ADDR_ACC
                      || PADDR == ssx_pkg::ADDR_STATUS
                      || PADDR == ssx_pkg::ADDR_WDT;
   assign a_fidx    = PADDR[7:2];
   assign a_sidx    = PADDR[5:2];

   assign ex_op   = PWDATA[ssx_pkg::OP_LSB +: 4];
   assign ex_dest = PWDATA[ssx_pkg::DEST_BIT];
   assign ex_fidx = PWDATA[ssx_pkg::FIDX_LSB +: 6];
   assign ex_sidx = PWDATA[ssx_pkg::SIDX_LSB +: 4];
   assign ex_imm  = PWDATA[ssx_pkg::IMM_LSB +: 8];

   // Instructions only run while the core is not halted
   assign refused = wr && PADDR == ssx_pkg::ADDR_INSTR
                    && s_r.mode != ssx_pkg::SSX_RUN;
   assign exec    = wr && PADDR == ssx_pkg::ADDR_INSTR
                    && s_r.mode == ssx_pkg::SSX_RUN;

   //-----------------------------------------------------------------------
   // Read data and operand selection
   //-----------------------------------------------------------------------
   always_comb begin
      rd_val = 32'h0000_0000;
      if (hit_freg) begin
         rd_val[7:0] = s_r.freg[a_fidx];
      end else if (hit_spage) begin
         rd_val[7:0] = s_r.spage[a_sidx];
      end else begin
         case (PADDR)
            ssx_pkg::ADDR_ACC: begin
               rd_val[7:0] = s_r.acc;
            end
            ssx_pkg::ADDR_STATUS: begin
               rd_val[ssx_pkg::ST_C]    = s_r.c;
               rd_val[ssx_pkg::ST_DC]   = s_r.dc;
               rd_val[ssx_pkg::ST_Z]    = s_r.z;
               rd_val[ssx_pkg::ST_PD_N] = s_r.pd_n;
               rd_val[ssx_pkg::ST_TO_N] = s_r.to_n;
               rd_val[ssx_pkg::ST_HALT] = s_r.mode == ssx_pkg::SSX_HALTED;
            end
            ssx_pkg::ADDR_WDT: begin
               rd_val[15:0] = {s_r.pre, s_r.wdt};
            end
            default: begin
               rd_val = 32'h0000_0000;
            end
         endcase
      end
   end

   always_comb begin
      case (ex_op)
         ssx_pkg::OP_REG_SBC: begin
            alu = sub8(s_r.freg[ex_fidx], s_r.acc, s_r.c);
         end
         ssx_pkg::OP_IMM_SBC: begin
            alu = sub8(ex_imm, s_r.acc, s_r.c);
         end
         ssx_pkg::OP_REG_SUB: begin
            alu = sub8(s_r.freg[ex_fidx], s_r.acc, 1'b1);
         end
         default:             alu = sub8(8'h00, 8'h00, 1'b0);
      endcase
   end

   //-----------------------------------------------------------------------
   // Next state
   //-----------------------------------------------------------------------
   always_comb begin
      s_nxt = s_r;
      if (setup) begin
         s_nxt.prdata = rd_val;
      end
      if (s_r.mode == ssx_pkg::SSX_HALT_PEND) begin
         s_nxt.mode = ssx_pkg::SSX_HALTED;
      end
      if (wr && hit_freg) begin
         s_nxt.freg[a_fidx] = PWDATA[7:0];
      end
      if (wr && hit_spage) begin
         s_nxt.spage[a_sidx] = PWDATA[7:0];
      end
      if (wr && PADDR == ssx_pkg::ADDR_ACC) begin
         s_nxt.acc = PWDATA[7:0];
      end
      if (wr && PADDR == ssx_pkg::ADDR_WDT) begin
         s_nxt.wdt = PWDATA[7:0];
         s_nxt.pre = PWDATA[15:8];
      end
      if (wr && PADDR == ssx_pkg::ADDR_STATUS) begin
         s_nxt.c    = PWDATA[ssx_pkg::ST_C];
         s_nxt.dc   = PWDATA[ssx_pkg::ST_DC];
         s_nxt.z    = PWDATA[ssx_pkg::ST_Z];
         s_nxt.pd_n = PWDATA[ssx_pkg::ST_PD_N];
         s_nxt.to_n = PWDATA[ssx_pkg::ST_TO_N];
         // Writing halt bit low resumes a halted core
         if (s_r.mode == ssx_pkg::SSX_HALTED
             && !PWDATA[ssx_pkg::ST_HALT]) begin
            s_nxt.mode = ssx_pkg::SSX_RUN;
         end
      end
      if (exec) begin
         case (ex_op)
            ssx_pkg::OP_REG_SBC,
            ssx_pkg::OP_REG_SUB: begin
               s_nxt.c  = alu.c;
               s_nxt.dc = alu.dc;
               s_nxt.z  = alu.res == 8'h00;
               if (ex_dest) begin
                  s_nxt.freg[ex_fidx] = alu.res;
               end else begin
                  s_nxt.acc = alu.res;
               end
            end
            ssx_pkg::OP_IMM_SBC: begin
               s_nxt.c   = alu.c;
               s_nxt.dc  = alu.dc;
               s_nxt.z   = alu.res == 8'h00;
               s_nxt.acc = alu.res;
            end
            ssx_pkg::OP_SP_STORE: begin
               s_nxt.spage[ex_sidx] = s_r.acc;
            end
            ssx_pkg::OP_SP_LOAD: begin
               s_nxt.acc = s_r.spage[ex_sidx];
            end
            ssx_pkg::OP_HALT: begin
               s_nxt.wdt  = ssx_pkg::RST_WDT;
               s_nxt.pre  = ssx_pkg::RST_PRE;
               s_nxt.to_n = 1'b1;
               s_nxt.pd_n = 1'b0;
               s_nxt.mode = ssx_pkg::SSX_HALT_PEND;
            end
            default: begin
               s_nxt.mode = s_r.mode;
            end
         endcase
      end
   end

   always_ff @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         s_r        <= '0;
         s_r.mode   <= ssx_pkg::SSX_RUN;
         s_r.acc    <= ssx_pkg::RST_ACC;
         s_r.to_n   <= ssx_pkg::RST_TO_N;
         s_r.pd_n   <= ssx_pkg::RST_PD_N;
         s_r.wdt    <= ssx_pkg::RST_WDT;
         s_r.pre    <= ssx_pkg::RST_PRE;
      end else begin
         s_r <= s_nxt;
      end
   end

   //-----------------------------------------------------------------------
   // Outputs
   //-----------------------------------------------------------------------
   assign PRDATA    = s_r.prdata;
   assign PREADY    = 1'b1;
   assign PSLVERR   = access && (!mapped || refused);
   assign HALT_MODE = s_r.mode == ssx_pkg::SSX_HALTED;

   //-----------------------------------------------------------------------
   // Checks
   //-----------------------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);

   logic [8:0] x_sbc;
   logic [8:0] x_sub;
   logic [8:0] x_imm;
   logic [4:0] x_dc;
   logic       x_arith;

   assign x_sbc   = {1'b0, s_r.freg[ex_fidx]} + {1'b0, ~s_r.acc}
                    + {8'h00, s_r.c};
   assign x_sub   = {1'b0, s_r.freg[ex_fidx]} - {1'b0, s_r.acc};
   assign x_imm   = {1'b0, ex_imm} + {1'b0, ~s_r.acc} + {8'h00, s_r.c};
   assign x_dc    = {1'b0, ex_imm[3:0]} + {1'b0, ~s_r.acc[3:0]}
                    + {4'h0, s_r.c};
   assign x_arith = exec && (ex_op == ssx_pkg::OP_REG_SBC
                    || ex_op == ssx_pkg::OP_IMM_SBC
                    || ex_op == ssx_pkg::OP_REG_SUB);

   property p_sbc_acc;
      logic [8:0] e;
      (exec && ex_op == ssx_pkg::OP_REG_SBC && !ex_dest, e = x_sbc)
      |=> s_r.acc == e[7:0] && s_r.c == e[8];
   endproperty
   a_sbc_acc: assert property (p_sbc_acc)
      else $error("sbc to acc wrong");

   property p_dest_file;
      logic [5:0] i;
      logic [7:0] e;
      (exec && ex_op == ssx_pkg::OP_REG_SBC && ex_dest, i = ex_fidx,
       e = x_sbc[7:0]) |=> s_r.freg[i] == e && $stable(s_r.acc);
   endproperty
   a_dest_file: assert property (p_dest_file)
      else $error("dest file wrong");

   property p_fidx_range;
      logic [7:0] e;
      (exec && ex_op == ssx_pkg::OP_REG_SUB && ex_dest && ex_fidx == 6'h3F,
       e = x_sub[7:0]) |=> s_r.freg[63] == e;
   endproperty
   a_fidx_range: assert property (p_fidx_range)
      else $error("reg 63 wrong");

   property p_borrow;
      exec && ex_op == ssx_pkg::OP_IMM_SBC && ex_imm == 8'h05
      && s_r.acc == 8'h06 && !s_r.c |=> s_r.acc == 8'hFE && !s_r.c;
   endproperty
   a_borrow: assert property (p_borrow)
      else $error("borrow case wrong");

   property p_zero;
      exec && ex_op == ssx_pkg::OP_IMM_SBC && ex_imm == 8'h06
      && s_r.acc == 8'h05 && !s_r.c |=> s_r.acc == 8'h00 && s_r.z && s_r.c;
   endproperty
   a_zero: assert property (p_zero)
      else $error("zero case wrong");

   property p_store;
      logic [3:0] i;
      logic [7:0] v;
      (exec && ex_op == ssx_pkg::OP_SP_STORE, i = ex_sidx, v = s_r.acc)
      |=> s_r.spage[i] == v && s_r.acc == v;
   endproperty
   a_store: assert property (p_store)
      else $error("store wrong");

   property p_load;
      logic [7:0] v;
      (exec && ex_op == ssx_pkg::OP_SP_LOAD, v = s_r.spage[ex_sidx])
      |=> s_r.acc == v && $stable({s_r.c, s_r.dc, s_r.z});
   endproperty
   a_load: assert property (p_load)
      else $error("load wrong");

   property p_halt_clear;
      exec && ex_op == ssx_pkg::OP_HALT |=> s_r.wdt == 8'h00
      && s_r.pre == 8'h00;
   endproperty
   a_halt_clear: assert property (p_halt_clear)
      else $error("wdt not clear");

   property p_halt_seq;
      exec && ex_op == ssx_pkg::OP_HALT |=> s_r.to_n && !s_r.pd_n
      && !HALT_MODE ##1 HALT_MODE;
   endproperty
   a_halt_seq: assert property (p_halt_seq)
      else $error("halt seq wrong");

   property p_sub;
      logic [8:0] e;
      (exec && ex_op == ssx_pkg::OP_REG_SUB && !ex_dest, e = x_sub)
      |=> s_r.acc == e[7:0] && s_r.c == !e[8];
   endproperty
   a_sub: assert property (p_sub)
      else $error("sub wrong");

   property p_imm;
      logic [7:0] e;
      (exec && ex_op == ssx_pkg::OP_IMM_SBC, e = x_imm[7:0])
      |=> s_r.acc == e;
   endproperty
   a_imm: assert property (p_imm)
      else $error("imm result wrong");

   property p_dc;
      logic d;
      (exec && ex_op == ssx_pkg::OP_IMM_SBC, d = x_dc[4]) |=> s_r.dc == d;
   endproperty
   a_dc: assert property (p_dc)
      else $error("digit carry wrong");

   property p_sub_dc;
      logic d;
      (exec && ex_op == ssx_pkg::OP_REG_SUB,
       d = s_r.freg[ex_fidx][3:0] >= s_r.acc[3:0]) |=> s_r.dc == d;
   endproperty
   a_sub_dc: assert property (p_sub_dc)
      else $error("sub digit carry wrong");

   property p_refuse;
      refused |=> HALT_MODE && $stable(s_r.acc)
      && $stable({s_r.c, s_r.dc, s_r.z});
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("refused instruction acted");

   c_arith: cover property (x_arith ##1 s_r.z);
   c_store: cover property (exec && ex_op == ssx_pkg::OP_SP_STORE);
   c_halt:  cover property (exec && ex_op == ssx_pkg::OP_HALT ##2 HALT_MODE);
   c_load:  cover property (exec && ex_op == ssx_pkg::OP_SP_LOAD);
   c_refuse: cover property (refused);

endmodule

// [bench/ssx_exec_bench.sv]
// Self-checking bench for the subtract, special-page and halt unit
module ssx_exec_bench;
   timeunit 1ns;
   timeprecision 1ps;

   logic        ref_clk = 1'b0;
   logic        rst     = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0000_0000;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        halt_mode;
   logic [31:0] rd;
   logic        err_seen;
   int          err_total   = 0;
   int          checks_done = 0;
   int          cycles      = 0;

   ssx_exec ssx_exec_inst (
      .REF_CLK   (ref_clk),
      .RST       (rst),
      .PSEL      (psel),
      .PENABLE   (penable),
      .PWRITE    (pwrite),
      .PADDR     (paddr),
      .PWDATA    (pwdata),
      .PRDATA    (prdata),
      .PREADY    (pready),
      .PSLVERR   (pslverr),
      .HALT_MODE (halt_mode)
   );

   always #2 ref_clk = ~ref_clk;

   //-----------------------------------------------------------------
   // Hang guard
   //-----------------------------------------------------------------
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_total++;
         print_verdict();
      end
   end

   //-----------------------------------------------------------------
   // Bus and checking tasks
   //-----------------------------------------------------------------
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      int n;
      n = 0;
      @(posedge ref_clk);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (pready !== 1'b1)
         err_total++;
      rd       = prdata;
      err_seen = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         err_total++;
         $display("mismatch %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic rd_chk(input string nm, input logic [11:0] a,
                         input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000);
      check(nm, rd, exp);
   endtask

   function automatic logic [31:0] stw(input logic c, dc, z, pd, to, h);
      return (32'(c) << ssx_pkg::ST_C) | (32'(dc) << ssx_pkg::ST_DC)
           | (32'(z) << ssx_pkg::ST_Z) | (32'(pd) << ssx_pkg::ST_PD_N)
           | (32'(to) << ssx_pkg::ST_TO_N) | (32'(h) << ssx_pkg::ST_HALT);
   endfunction

   function automatic logic [11:0] fa(input logic [5:0] i);
      return ssx_pkg::ADDR_FREG + {4'h0, i, 2'b00};
   endfunction

   function automatic logic [11:0] sa(input logic [3:0] i);
      return ssx_pkg::ADDR_SPAGE + {6'h00, i, 2'b00};
   endfunction

   function automatic logic [31:0] iw(input logic [3:0] op, input logic d,
                                      input logic [5:0] fi,
                                      input logic [3:0] si,
                                      input logic [7:0] imm);
      return {imm, 4'h0, si, 2'b00, fi, 3'b000, d, op};
   endfunction

   // Operand r is the file value, or the immediate for the immediate form
   task automatic alu(input logic [3:0] op, input logic d,
                      input logic [5:0] fi, input logic [7:0] r, a,
                      input logic ci);
      logic       imm;
      logic       cc;
      logic       to_acc;
      logic [7:0] fv;
      logic [8:0] s;
      logic [4:0] lo;
      imm    = (op == ssx_pkg::OP_IMM_SBC);
      cc     = (op == ssx_pkg::OP_REG_SUB) ? 1'b1 : ci;
      to_acc = imm || !d;
      fv     = imm ? 8'h3C : r;
      s      = {1'b0, r} + {1'b0, ~a} + {8'h00, cc};
      lo     = {1'b0, r[3:0]} + {1'b0, ~a[3:0]} + {4'h0, cc};
      apb(1'b1, fa(fi), {24'h000000, fv});
      apb(1'b1, ssx_pkg::ADDR_ACC, {24'h000000, a});
      apb(1'b1, ssx_pkg::ADDR_STATUS, stw(ci, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0));
      apb(1'b1, ssx_pkg::ADDR_INSTR, iw(op, d, fi, 4'h0, r));
      rd_chk("status", ssx_pkg::ADDR_STATUS,
             stw(s[8], lo[4], s[7:0] == 8'h00, 1'b1, 1'b1, 1'b0));
      rd_chk("acc", ssx_pkg::ADDR_ACC,
             {24'h000000, to_acc ? s[7:0] : a});
      rd_chk("freg", fa(fi), {24'h000000, to_acc ? fv : s[7:0]});
   endtask

   //-----------------------------------------------------------------
   // Test sequence
   //-----------------------------------------------------------------
   initial begin
      repeat (20) @(posedge ref_clk);
      rst <= 1'b0;
      rd_chk("acc", ssx_pkg::ADDR_ACC, 32'h0000_0000);
      rd_chk("status", ssx_pkg::ADDR_STATUS,
             stw(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0));
      rd_chk("wdt", ssx_pkg::ADDR_WDT, 32'h0000_0000);
      check("halt_mode", 32'(halt_mode), 32'h0000_0000);
      check("pready", 32'(pready), 32'h0000_0001);
      $display("test reset done");

      alu(ssx_pkg::OP_REG_SBC, 1'b1, 6'd5, 8'h05, 8'h06, 1'b0);
      alu(ssx_pkg::OP_REG_SBC, 1'b1, 6'd5, 8'h05, 8'h06, 1'b1);
      alu(ssx_pkg::OP_REG_SBC, 1'b1, 6'd5, 8'h06, 8'h05, 1'b0);
      alu(ssx_pkg::OP_REG_SBC, 1'b1, 6'd5, 8'h06, 8'h05, 1'b1);
      alu(ssx_pkg::OP_REG_SBC, 1'b0, 6'd63, 8'h10, 8'h01, 1'b1);
      alu(ssx_pkg::OP_REG_SBC, 1'b1, 6'd0, 8'h80, 8'h7F, 1'b0);
      alu(ssx_pkg::OP_IMM_SBC, 1'b1, 6'd7, 8'h05, 8'h06, 1'b0);
      alu(ssx_pkg::OP_IMM_SBC, 1'b0, 6'd7, 8'h05, 8'h06, 1'b1);
      alu(ssx_pkg::OP_IMM_SBC, 1'b1, 6'd7, 8'h06, 8'h05, 1'b0);
      alu(ssx_pkg::OP_IMM_SBC, 1'b0, 6'd7, 8'h06, 8'h05, 1'b1);
      alu(ssx_pkg::OP_REG_SUB, 1'b1, 6'd9, 8'h05, 8'h06, 1'b0);
      alu(ssx_pkg::OP_REG_SUB, 1'b0, 6'd63, 8'h06, 8'h05, 1'b0);
      alu(ssx_pkg::OP_REG_SUB, 1'b1, 6'd63, 8'h06, 8'h05, 1'b1);
      apb(1'b1, ssx_pkg::ADDR_INSTR,
          iw(ssx_pkg::OP_NOP, 1'b0, 6'd0, 4'h0, 8'h00));
      check("pslverr", 32'(err_seen), 32'h0000_0000);
      rd_chk("acc", ssx_pkg::ADDR_ACC, 32'h0000_0005);
      $display("test subtract done");

      for (int i = 0; i < 16; i += 15) begin
         apb(1'b1, ssx_pkg::ADDR_ACC, 32'h0000_00AA);
         apb(1'b1, ssx_pkg::ADDR_STATUS, stw(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0));
         apb(1'b1, sa(4'(i)), 32'h0000_0055);
         apb(1'b1, ssx_pkg::ADDR_INSTR, iw(ssx_pkg::OP_SP_STORE, 1'b0, 6'd0, 4'(i), 8'h00));
         rd_chk("spage", sa(4'(i)), 32'h0000_00AA);
         rd_chk("acc", ssx_pkg::ADDR_ACC, 32'h0000_00AA);
         apb(1'b1, sa(4'(i)), 32'h0000_005A);
         apb(1'b1, ssx_pkg::ADDR_INSTR, iw(ssx_pkg::OP_SP_LOAD, 1'b0, 6'd0, 4'(i), 8'h00));
         rd_chk("acc", ssx_pkg::ADDR_ACC, 32'h0000_005A);
         rd_chk("status", ssx_pkg::ADDR_STATUS, stw(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0));
      end
      $display("test special page done");

      apb(1'b1, ssx_pkg::ADDR_WDT, 32'h0000_3412);
      apb(1'b1, ssx_pkg::ADDR_STATUS, stw(1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0));
      apb(1'b1, ssx_pkg::ADDR_INSTR, iw(ssx_pkg::OP_HALT, 1'b0, 6'd0, 4'h0, 8'h00));
      @(negedge ref_clk);
      check("halt_mode", 32'(halt_mode), 32'h0000_0000);
      @(negedge ref_clk);
      check("halt_mode", 32'(halt_mode), 32'h0000_0001);
      rd_chk("wdt", ssx_pkg::ADDR_WDT, 32'h0000_0000);
      rd_chk("status", ssx_pkg::ADDR_STATUS, stw(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1));
      apb(1'b1, ssx_pkg::ADDR_INSTR, iw(ssx_pkg::OP_IMM_SBC, 1'b0, 6'd0, 4'h0, 8'h77));
      check("pslverr", 32'(err_seen), 32'h0000_0001);
      rd_chk("acc", ssx_pkg::ADDR_ACC, 32'h0000_005A);
      apb(1'b1, ssx_pkg::ADDR_STATUS, stw(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0));
      rd_chk("status", ssx_pkg::ADDR_STATUS, stw(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b0));
      @(negedge ref_clk);
      check("halt_mode", 32'(halt_mode), 32'h0000_0000);
      $display("test halt done");

      apb(1'b0, 12'h010, 32'h0000_0000);
      check("pslverr", 32'(err_seen), 32'h0000_0001);
      check("unmapped", rd, 32'h0000_0000);
      $display("test unmapped done");
      print_verdict();
   end

endmodule
